// ---- hw/odtp_pkg.sv ----
// package: constants and types for the odt power-down entry transition block
package odtp_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 100000;
  localparam int ASYNC_DLY_MIN_PS = 2000;
  localparam int ASYNC_DLY_MAX_PS = 8500;
  localparam int TRANS_MIN_PS = 1000;
  localparam int TRANS_MAX_PS = 9000;
  // least times round up, longest round down, never below one cycle
  localparam int ASYNC_MIN_CYC_RAW = (ASYNC_DLY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_MAX_CYC_RAW = ASYNC_DLY_MAX_PS / CLK_PERIOD_PS;
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
  localparam int ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int MR0_DLL_PD_BIT = 12;
  localparam int LAT_W = 6;
  localparam int RFC_W = 10;
  localparam logic [LAT_W-1:0] LAT_ONE = 6'h01;
  localparam logic [LAT_W-1:0] LAT_TWO = 6'h02;
  localparam logic [RFC_W-1:0] RFC_DEF = 10'h040;
  localparam logic [LAT_W-1:0] CWL_DEF = 6'h05;

  typedef enum logic [1:0] {
    ODTP_SYNC = 2'b00,
    ODTP_TRANS = 2'b01,
    ODTP_ASYNC = 2'b11
  } odtp_mode_t;
endpackage

// ---- hw/odtp_lat_if.sv ----
// interface: latency values shared between top and termination path
`timescale 1ns/1ps
interface odtp_lat_if;
  logic [odtp_pkg::LAT_W-1:0] term_lat;
  logic [1:0] mode;
  logic odt_req;
  logic term_on;
  modport ctl (output term_lat, output mode, output odt_req, input term_on);
  modport path (input term_lat, input mode, input odt_req, output term_on);
endinterface

// ---- hw/odtp_term_path.sv ----
// module: termination path with synchronous latency or asynchronous delay
`timescale 1ns/1ps
module odtp_term_path
  import odtp_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  odtp_lat_if.path lat
);
  import odtp_pkg::*;
  // ----------------------------------------------------------------
  // synchronous delay line, asynchronous settle counter
  // ----------------------------------------------------------------
  logic [DEPTH-1:0] line;
  logic [DEPTH-1:0] next_line;
  logic [3:0] settle;
  logic [3:0] next_settle;
  logic term_on;
  logic next_term_on;
  logic async_tgt;
  logic next_async_tgt;

  always_comb begin
    next_line = {line[DEPTH-2:0], lat.odt_req};
    next_settle = settle;
    next_async_tgt = async_tgt;
    next_term_on = term_on;
    if (lat.mode == ODTP_ASYNC) begin
      // no additive latency: raw sampled pin drives the target
      if (lat.odt_req != async_tgt) begin
        next_async_tgt = lat.odt_req;
        next_settle = 4'h0;
      end else if (settle < 4'(ASYNC_MAX_CYC)) begin
        next_settle = settle + 4'h1;
      end
      // whole-cycle clock is coarser than 2..8.5 ns; change lands one edge later
      if (next_settle >= 4'(ASYNC_MIN_CYC) || settle >= 4'(ASYNC_MIN_CYC)) begin
        next_term_on = async_tgt;
      end
    end else if (lat.term_lat == '0) begin
      next_term_on = lat.odt_req;
    end else begin
      // both on and off use the same latency
      next_term_on = line[lat.term_lat - LAT_ONE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      line <= '0;
      settle <= '0;
      term_on <= 1'b0;
      async_tgt <= 1'b0;
    end else if (i_ce) begin
      line <= next_line;
      settle <= next_settle;
      term_on <= next_term_on;
      async_tgt <= next_async_tgt;
    end
  end

  assign lat.term_on = term_on;
endmodule // odtp_term_path

// ---- hw/odtp_entry.sv ----
// module: odt synchronous-to-asynchronous transition at power-down entry
`timescale 1ns/1ps
module odtp_entry
  import odtp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_cke,
  input wire logic i_odt,
  input wire logic i_refresh,
  input wire logic i_mr0_dll_pd,
  input wire logic [odtp_pkg::LAT_W-1:0] i_cas_write_latency,
  input wire logic [odtp_pkg::LAT_W-1:0] i_additive_latency,
  input wire logic [odtp_pkg::RFC_W-1:0] i_refresh_cycle_time,
  output logic o_term_on,
  output logic o_in_transition,
  output logic o_async_mode,
  output logic [odtp_pkg::LAT_W-1:0] o_entry_window_interval
);
  import odtp_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cke_sy;
  logic [2:0] odt_sy;
  logic cke_s;
  logic odt_s;
  logic next_cke_s;
  logic next_odt_s;

  // a pin change is taken only once the two older flops agree, so a
  // metastable first stage can never reach the sequencer
  function automatic logic vote(input logic [2:0] sy, input logic held);
    return (sy[1] == sy[2]) ? sy[2] : held;
  endfunction

  always_comb begin
    next_cke_s = vote(cke_sy, cke_s);
    next_odt_s = vote(odt_sy, odt_s);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cke_sy <= 3'b000;
      odt_sy <= 3'b000;
      cke_s <= 1'b0;
      odt_s <= 1'b0;
    end else if (i_ce) begin
      cke_sy <= {cke_sy[1:0], i_cke};
      odt_sy <= {odt_sy[1:0], i_odt};
      cke_s <= next_cke_s;
      odt_s <= next_odt_s;
    end
  end

  // ----------------------------------------------------------------
  // latency arithmetic
  // ----------------------------------------------------------------
  function automatic logic [LAT_W-1:0] sat_sub(input logic [LAT_W-1:0] a,
                                               input logic [LAT_W-1:0] b);
    return (a > b) ? a - b : '0;
  endfunction

  logic [LAT_W-1:0] wl;
  logic [LAT_W-1:0] term_lat;
  logic [LAT_W-1:0] anpd;
  always_comb begin
    wl = i_cas_write_latency + i_additive_latency;
    term_lat = sat_sub(wl, LAT_TWO);
    // max(off+1, on+1) collapses to write latency minus one
    anpd = sat_sub(wl, LAT_ONE);
  end

  // ----------------------------------------------------------------
  // entry sequencing
  // ----------------------------------------------------------------
  // the controller announces entry only by cke; the device cannot see the
  // future, so the opening edge is tracked as anpd cycles after cke goes high
  odtp_mode_t mode;
  odtp_mode_t next_mode;
  logic in_trans;
  logic next_in_trans;
  logic [LAT_W-1:0] win;
  logic [LAT_W-1:0] next_win;
  logic async_q;
  logic next_async_q;

  // ----------------------------------------------------------------
  // refresh tracking
  // ----------------------------------------------------------------
  // a refresh still running at cke low pushes the end of the window out
  localparam logic [RFC_W-1:0] RFC_ONE = {{(RFC_W-1){1'b0}}, 1'b1};
  logic [RFC_W-1:0] rfc_cnt;
  logic [RFC_W-1:0] next_rfc_cnt;
  logic rfc_busy;
  logic rfc_last;

  always_comb begin
    rfc_busy = (rfc_cnt != '0);
    rfc_last = (rfc_cnt == RFC_ONE);
    next_rfc_cnt = rfc_busy ? rfc_cnt - RFC_ONE : rfc_cnt;
    if (i_refresh) begin
      // a new command restarts the count
      next_rfc_cnt = i_refresh_cycle_time;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rfc_cnt <= '0;
    end else if (i_ce) begin
      rfc_cnt <= next_rfc_cnt;
    end
  end

  // ----------------------------------------------------------------
  // cke high history
  // ----------------------------------------------------------------
  // saturates instead of wrapping, so a long idle never closes the window
  logic [LAT_W-1:0] hi_cnt;
  logic [LAT_W-1:0] next_hi_cnt;
  logic cke_d;
  logic next_cke_d;
  logic cke_fell;

  always_comb begin
    cke_fell = cke_d && !cke_s;
    next_cke_d = cke_s;
    next_hi_cnt = hi_cnt;
    if (cke_fell && mode == ODTP_SYNC) begin
      next_hi_cnt = '0;
    end else if (cke_s && hi_cnt != '1) begin
      next_hi_cnt = hi_cnt + LAT_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hi_cnt <= '0;
      cke_d <= 1'b0;
    end else if (i_ce) begin
      hi_cnt <= next_hi_cnt;
      cke_d <= next_cke_d;
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    next_win = anpd;
    next_async_q = (mode == ODTP_ASYNC);
    next_in_trans = 1'b0;
    unique case (mode)
      ODTP_SYNC: begin
        // window open once cke has been high for anpd cycles, until cke low
        next_in_trans = i_mr0_dll_pd == 1'b0 && cke_s && hi_cnt >= anpd;
        if (cke_fell) begin
          if (i_mr0_dll_pd == 1'b0) begin
            if (rfc_busy) begin
              next_mode = ODTP_TRANS;
              next_in_trans = 1'b1;
            end else begin
              next_mode = ODTP_ASYNC;
            end
          end
        end
      end
      ODTP_TRANS: begin
        // length becomes the remaining refresh time; anpd is not counted after cke low
        next_in_trans = 1'b1;
        if (!rfc_busy || rfc_last) begin
          next_mode = ODTP_ASYNC;
          next_in_trans = 1'b0;
        end
        if (cke_s) begin
          next_mode = ODTP_SYNC;
          next_in_trans = 1'b0;
        end
      end
      ODTP_ASYNC: begin
        // exit handling lies elsewhere; cke high returns to synchronous
        if (cke_s) begin
          next_mode = ODTP_SYNC;
        end
      end
      default: begin
        next_mode = ODTP_SYNC;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode <= ODTP_SYNC;
      in_trans <= 1'b0;
      win <= '0;
      async_q <= 1'b0;
    end else if (i_ce) begin
      mode <= next_mode;
      in_trans <= next_in_trans;
      win <= next_win;
      async_q <= next_async_q;
    end
  end

  // ----------------------------------------------------------------
  // termination path
  // ----------------------------------------------------------------
  odtp_lat_if lat_bus ();
  assign lat_bus.term_lat = term_lat;
  assign lat_bus.mode = mode;
  assign lat_bus.odt_req = odt_s;

  odtp_term_path #(
    .DEPTH(64)
  ) i_odtp_term_path (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .lat(lat_bus)
  );

  // async flag lags the internal mode by one cycle so it leaves a flop
  assign o_term_on = lat_bus.term_on;
  assign o_in_transition = in_trans;
  assign o_async_mode = async_q;
  assign o_entry_window_interval = win;
endmodule // odtp_entry

// ---- tb/odtp_entry_monitor.sv ----
// checker: port assertions for the odt entry transition block
`timescale 1ns/1ps
module odtp_entry_monitor (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cke,
  input wire logic i_odt,
  input wire logic i_mr0_dll_pd,
  input wire logic [odtp_pkg::LAT_W-1:0] i_cas_write_latency,
  input wire logic [odtp_pkg::LAT_W-1:0] i_additive_latency,
  input wire logic o_term_on,
  input wire logic o_in_transition,
  input wire logic o_async_mode,
  input wire logic [odtp_pkg::LAT_W-1:0] o_entry_window_interval
);
  import odtp_pkg::*;
  logic [LAT_W-1:0] wl;
  assign wl = i_cas_write_latency + i_additive_latency;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_EWI: assert property ($stable(wl) && wl == $past(wl, 2) |=>
    o_entry_window_interval == $past(wl) - LAT_ONE) else $error("window interval");
  AST_MR0: assert property (i_mr0_dll_pd |-> !o_in_transition && !o_async_mode)
    else $error("dll on yet transition");
  AST_RISE: assert property ($rose(o_in_transition) |-> $past(i_cke, 3) && $past(i_cke, 4))
    else $error("transition without cke high");
  AST_END: assert property ($fell(o_in_transition) |-> ##[0:2] o_async_mode)
    else $error("transition end not async");
  AST_ARISE: assert property ($rose(o_async_mode) |-> !$past(i_cke, 3) && !$past(i_cke, 4))
    else $error("async without cke low");
  AST_AON: assert property (o_async_mode && $rose(i_odt) |->
    !o_term_on ##1 !o_term_on ##[1:8] o_term_on) else $error("async turn on");
  AST_AOF: assert property (o_async_mode && $fell(i_odt) |->
    o_term_on ##1 o_term_on ##[1:8] !o_term_on) else $error("async turn off");
  // sync path needs the odt latency plus the pin synchroniser
  AST_SYNC: assert property (!o_async_mode && i_cke && wl == 6'h05 && $rose(i_odt) |->
    !o_term_on [*5] ##[1:6] o_term_on) else $error("sync turn on");
  cover property ($rose(o_async_mode));
  cover property ($fell(o_in_transition));
  cover property (o_async_mode && $rose(o_term_on));
endmodule // odtp_entry_monitor
bind odtp_entry odtp_entry_monitor i_odtp_entry_monitor (.*);

// ---- tb/odtp_ctrl_model.sv ----
// partner: memory controller driving cke, odt and refresh
`timescale 1ns/1ps
module odtp_ctrl_model (
  input wire logic i_clk,
  output logic o_cke,
  output logic o_odt,
  output logic o_refresh
);
  initial begin
    o_cke = 1'b1;
    o_odt = 1'b0;
    o_refresh = 1'b0;
  end
  // odt only moves when the bench asks, also inside the transition window
  task automatic drive(input logic cke, input logic odt, input int n);
    @(posedge i_clk);
    o_cke <= cke;
    o_odt <= odt;
    repeat (n) @(posedge i_clk);
  endtask
  task automatic refresh();
    @(posedge i_clk);
    o_refresh <= 1'b1;
    @(posedge i_clk);
    o_refresh <= 1'b0;
  endtask
endmodule // odtp_ctrl_model

// ---- tb/odtp_entry_tb.sv ----
// testbench: odt power-down entry transition scenarios
`timescale 1ns/1ps
module odtp_entry_tb;
  import odtp_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic mr0 = 1'b1;
  logic [LAT_W-1:0] cas_write_latency = CWL_DEF;
  logic [LAT_W-1:0] al = 6'h00;
  logic [RFC_W-1:0] rfc = RFC_DEF;
  logic cke, odt, refr, term_on, in_trans, async_mode;
  logic [LAT_W-1:0] ewi;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 i_clk = ~i_clk;
  odtp_ctrl_model i_odtp_ctrl_model (.i_clk(i_clk), .o_cke(cke), .o_odt(odt), .o_refresh(refr));
  odtp_entry i_odtp_entry (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_cke(cke),
    .i_odt(odt), .i_refresh(refr), .i_mr0_dll_pd(mr0), .i_cas_write_latency(cas_write_latency),
    .i_additive_latency(al), .i_refresh_cycle_time(rfc), .o_term_on(term_on),
    .o_in_transition(in_trans), .o_async_mode(async_mode), .o_entry_window_interval(ewi));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic do_reset(input logic dll);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    mr0 <= dll;
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    check("reset trans", in_trans, 1'b0);
    check("reset async", async_mode, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_dll_on();
    do_reset(1'b1);
    i_odtp_ctrl_model.drive(1'b1, 1'b0, 20);
    i_odtp_ctrl_model.drive(1'b1, 1'b1, 15);
    #1;
    check("sync term", term_on, 1'b1);
    check("no trans", in_trans, 1'b0);
    i_odtp_ctrl_model.drive(1'b0, 1'b0, 10);
    #1;
    check("no async", async_mode, 1'b0);
  endtask
  task automatic t_window();
    logic [LAT_W-1:0] c [3] = '{6'h05, 6'h06, 6'h08};
    logic [LAT_W-1:0] a [3] = '{6'h00, 6'h05, 6'h07};
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      cas_write_latency <= c[k];
      al <= a[k];
      repeat (3) @(posedge i_clk);
      #1;
      check("window", ewi, c[k] + a[k] - 6'h01);
    end
    cas_write_latency <= CWL_DEF;
    al <= 6'h00;
  endtask
  task automatic t_entry();
    do_reset(1'b0);
    i_odtp_ctrl_model.drive(1'b1, 1'b0, 20);
    #1;
    check("trans open", in_trans, 1'b1);
    i_odtp_ctrl_model.drive(1'b1, 1'b1, 12);
    #1;
    check("entry on", term_on, 1'b1);
    i_odtp_ctrl_model.drive(1'b1, 1'b0, 12);
    #1;
    check("entry off", term_on, 1'b0);
    i_odtp_ctrl_model.drive(1'b0, 1'b0, 8);
    #1;
    check("trans closed", in_trans, 1'b0);
    check("async", async_mode, 1'b1);
  endtask
  // a large additive latency would push a sync answer far past the bound
  task automatic t_async_odt();
    int n;
    @(posedge i_clk);
    al <= 6'h14;
    for (int v = 1; v >= 0; v--) begin
      n = 0;
      i_odtp_ctrl_model.drive(1'b0, v[0], 0);
      while (term_on !== v[0] && n < 30) begin
        @(posedge i_clk);
        #1;
        n++;
      end
      check("async delay", n <= 8, 1'b1);
      check("async kept", async_mode, 1'b1);
    end
    al <= 6'h00;
  endtask
  task automatic t_refresh();
    @(posedge i_clk);
    rfc <= 10'h01E;
    do_reset(1'b0);
    i_odtp_ctrl_model.drive(1'b1, 1'b0, 20);
    i_odtp_ctrl_model.refresh();
    i_odtp_ctrl_model.drive(1'b0, 1'b0, 20);
    #1;
    check("refresh holds", in_trans, 1'b1);
    check("not async yet", async_mode, 1'b0);
    repeat (15) @(posedge i_clk);
    #1;
    check("refresh done", async_mode, 1'b1);
  endtask
  initial begin
    t_dll_on();
    t_window();
    t_entry();
    t_async_odt();
    t_refresh();
    final_report();
  end
endmodule // odtp_entry_tb
